// file: verilog/overlay_pkg.sv
/*
 * Constants and carrier types for the configuration overlay validator.
 * Assumes a single 40 MHz core clock and a synchronous active-low reset.
 */
package overlay_pkg;

	// ----------------------------------------------------------------
	// Overlay layout
	// ----------------------------------------------------------------
	localparam int unsigned OVL_WORDS = 256;
	localparam logic [7:0] WORD_REVISION = 8'h00;
	localparam logic [7:0] WORD_UDMA = 8'h02;
	localparam logic [7:0] WORD_LBA_FIRST = 8'h03;
	localparam logic [7:0] WORD_LBA_LAST = 8'h06;
	localparam logic [7:0] WORD_FEATURE = 8'h07;
	localparam logic [7:0] WORD_INTEGRITY = 8'hFF;
	localparam logic [15:0] REVISION_VALUE = 16'h0001;
	localparam logic [7:0] SIGNATURE_VALUE = 8'hA5;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned UDMA_BITS = 3;
	localparam int unsigned FEAT_BITS = 9;
	localparam int unsigned FEAT_ADDR48 = 8;
	localparam int unsigned FEAT_PROT_AREA = 7;
	localparam int unsigned FEAT_SECURITY = 3;
	localparam int unsigned FEAT_SMART_LOG = 2;
	localparam int unsigned FEAT_SMART_TEST = 1;
	localparam int unsigned FEAT_SMART = 0;

	// ----------------------------------------------------------------
	// Values after reset, and the vendor byte left by each command
	// ----------------------------------------------------------------
	localparam logic [2:0] UDMA_RESET = 3'h7;
	localparam logic [8:0] FEAT_RESET = 9'h1FF;
	localparam logic [63:0] MAX_LBA_RESET = 64'h0000_0000_0FFF_FFFF;
	// Arbitrary vendor unique byte left in the sector count output
	localparam logic [7:0] VENDOR_RESULT = 8'h5A;

	// Current device state that the checks compare against
	typedef struct packed {
		logic freezeLock;
		logic protectedHostArea;
		logic securityEnabled;
		logic smartEnabled;
		logic udmaSelected;
		logic [2:0] udmaMode;
	} dev_state_s;

	// Result of one command as seen by the task-file outputs
	typedef struct packed {
		logic [7:0] failWordIndex;
		logic [15:0] failBitMask;
		logic [7:0] vendorResult;
	} fail_report_s;

endpackage

// file: verilog/byte_sum_acc.sv
/*
 * Running byte sum over a stream of 16-bit words.
 * Assumes add and clear are synchronous to the core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module byte_sum_acc (
	input wire logic clock, // Core clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic clear, // Restart the sum
	input wire logic add, // Add both bytes of word
	input wire logic [15:0] word, // Word to accumulate
	output logic [7:0] sum // Modulo 256 sum so far
);

	logic [7:0] sum_ff;

	// Both bytes go in at once, overflow is discarded by design
	always_ff @(posedge clock) begin
		if (!rst_n || clear) begin
			sum_ff <= 8'h00;
		end else if (add) begin
			sum_ff <= sum_ff + word[15:8] + word[7:0];
		end
	end

	assign sum = sum_ff;

endmodule // byte_sum_acc

`default_nettype wire

// file: verilog/config_overlay_validator.sv
/*
 * Device configuration overlay validator: receives the 256-word overlay,
 * checks integrity and modification limits, then commits or aborts.
 * Assumes the command decoder pulses cmdStart and then presents words
 * one per dataValid strobe, all on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module config_overlay_validator
	import overlay_pkg::*;
(
	input wire logic clock, // 40 MHz core clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic cmdStart, // Pulse: configuration set command begins
	input wire logic dataValid, // Pulse: dataWord holds next word
	input wire logic [15:0] dataWord, // Overlay word
	input wire dev_state_s devState, // Current device state
	input wire logic drive_select_bit, // Selected drive from host
	output logic cmdDone, // Pulse: command finished
	output logic cmdAbort, // Level: last command aborted
	output logic [7:0] fail_word_index, // Word that could not change
	output logic [7:0] fail_bit_mask_high, // Offending bits 15-8
	output logic [7:0] fail_bit_mask_low, // Offending bits 7-0
	output logic [7:0] vendor_result_byte, // Vendor unique result
	output logic [7:0] drive_select_reg, // Drive select status byte
	output logic [2:0] udmaSupport, // Configured DMA support bits
	output logic [8:0] featureSupport, // Configured feature bits
	output logic [63:0] identMaxLba // Maximum address for identify
);

	// ----------------------------------------------------------------
	// State and storage
	// ----------------------------------------------------------------
	typedef enum {IDLE, RECV, CHECK} ovl_state_e;

	ovl_state_e state_ff, nxt_state;
	logic [7:0] wordCnt_ff;
	logic [15:0] revWord_ff, udmaWord_ff, featWord_ff, integWord_ff;
	logic [63:0] lbaWord_ff;
	logic [2:0] udma_ff;
	logic [8:0] feat_ff;
	logic [63:0] maxLba_ff;
	logic done_ff, abort_ff;
	fail_report_s report_ff, nxt_report;
	logic [7:0] drvReg_ff;
	logic [7:0] byteSum;
	logic lastWord;
	logic failInteg, failUdma, failFeat, failLba, anyFail;
	logic [2:0] udmaBad;
	logic [8:0] featBad;

	assign lastWord = dataValid && (wordCnt_ff == WORD_INTEGRITY);

	// ----------------------------------------------------------------
	// Command sequencing
	// ----------------------------------------------------------------
	// Next-state: idle until start, then the full stream, then one check
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			IDLE: begin
				if (cmdStart) begin
					nxt_state = RECV;
				end
			end
			RECV: begin
				if (lastWord) begin
					nxt_state = CHECK;
				end
			end
			CHECK: nxt_state = IDLE;
			default: nxt_state = IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_ff <= IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Word counter; cleared by start so a stray word cannot skew it
	always_ff @(posedge clock) begin
		if (!rst_n || cmdStart) begin
			wordCnt_ff <= 8'h00;
		end else if (state_ff == RECV && dataValid) begin
			wordCnt_ff <= wordCnt_ff + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Capture of meaningful words
	// ----------------------------------------------------------------
	// reserved words feed only the checksum
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			revWord_ff <= 16'h0000;
			udmaWord_ff <= 16'h0000;
			featWord_ff <= 16'h0000;
			integWord_ff <= 16'h0000;
			lbaWord_ff <= 64'h0000_0000_0000_0000;
		end else if (state_ff == RECV && dataValid) begin
			if (wordCnt_ff == WORD_REVISION) begin
				revWord_ff <= dataWord;
			end
			if (wordCnt_ff == WORD_UDMA) begin
				udmaWord_ff <= dataWord;
			end
			if (wordCnt_ff == WORD_FEATURE) begin
				featWord_ff <= dataWord;
			end
			if (wordCnt_ff == WORD_INTEGRITY) begin
				integWord_ff <= dataWord;
			end
			if (wordCnt_ff >= WORD_LBA_FIRST && wordCnt_ff <= WORD_LBA_LAST) begin
				lbaWord_ff <= {dataWord, lbaWord_ff[63:16]};
			end
		end
	end

	// every byte, checksum byte included, goes into one sum
	byte_sum_acc u_sum (
		.clock(clock),
		.rst_n(rst_n),
		.clear(cmdStart),
		.add(state_ff == RECV && dataValid),
		.word(dataWord),
		.sum(byteSum)
	);

	// ----------------------------------------------------------------
	// Checks, evaluated in the CHECK cycle
	// ----------------------------------------------------------------
	// revision word; signature; sum must be zero
	assign failInteg = (revWord_ff != REVISION_VALUE) ||
		(integWord_ff[7:0] != SIGNATURE_VALUE) || (byteSum != 8'h00);

	// support bits are a thermometer; forbid unsafe clears
	always_comb begin
		udmaBad = 3'h0;
		for (int i = 0; i < UDMA_BITS; i++) begin
			if (udma_ff[i] && !udmaWord_ff[i]) begin
				udmaBad[i] = (|(udmaWord_ff[UDMA_BITS-1:0] >> (i + 1))) ||
					(devState.udmaSelected && devState.udmaMode >= 3'(i));
			end
		end
	end
	assign failUdma = |udmaBad;

	// these flags may not clear while their feature is in use
	always_comb begin
		featBad = 9'h000;
		featBad[FEAT_PROT_AREA] = feat_ff[FEAT_PROT_AREA] &&
			!featWord_ff[FEAT_PROT_AREA] && devState.protectedHostArea;
		featBad[FEAT_SECURITY] = feat_ff[FEAT_SECURITY] &&
			!featWord_ff[FEAT_SECURITY] && devState.securityEnabled;
		// base monitoring needs sub-flags gone and not enabled
		featBad[FEAT_SMART] = feat_ff[FEAT_SMART] && !featWord_ff[FEAT_SMART] &&
			(featWord_ff[FEAT_SMART_LOG] || featWord_ff[FEAT_SMART_TEST] ||
			devState.smartEnabled);
	end
	assign failFeat = |featBad;

	// an established protected area pins the maximum address
	assign failLba = devState.protectedHostArea && (lbaWord_ff != maxLba_ff);

	assign anyFail = devState.freezeLock || failInteg || failUdma ||
		failFeat || failLba;

	// report the first failing check (dma, then feature, then address); zero otherwise
	always_comb begin
		nxt_report.failWordIndex = 8'h00;
		nxt_report.failBitMask = 16'h0000;
		// vendor byte left after every command
		nxt_report.vendorResult = VENDOR_RESULT;
		if (devState.freezeLock || failInteg) begin
			nxt_report.failWordIndex = 8'h00;
		end else if (failUdma) begin
			nxt_report.failWordIndex = WORD_UDMA;
			nxt_report.failBitMask = {13'h0000, udmaBad};
		end else if (failFeat) begin
			nxt_report.failWordIndex = WORD_FEATURE;
			nxt_report.failBitMask = {7'h00, featBad};
		end else if (failLba) begin
			nxt_report.failWordIndex = WORD_LBA_FIRST;
		end
	end

	// ----------------------------------------------------------------
	// Result registers
	// ----------------------------------------------------------------
	// Outcome is latched so software can read it after the done pulse
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			done_ff <= 1'b0;
			abort_ff <= 1'b0;
			report_ff <= '0;
		end else begin
			done_ff <= (state_ff == CHECK);
			if (state_ff == CHECK) begin
				abort_ff <= anyFail;
				report_ff <= nxt_report;
			end
		end
	end

	// Drive select status follows the host's selection
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			drvReg_ff <= 8'h00;
		end else begin
			drvReg_ff <= {3'h0, drive_select_bit, 4'h0};
		end
	end

	// ----------------------------------------------------------------
	// Configuration commit
	// ----------------------------------------------------------------
	// all or nothing, so a partial commit can never be seen
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			udma_ff <= UDMA_RESET;
			feat_ff <= FEAT_RESET;
			maxLba_ff <= MAX_LBA_RESET;
		end else if (state_ff == CHECK && !anyFail) begin
			udma_ff <= udmaWord_ff[UDMA_BITS-1:0];
			feat_ff <= featWord_ff[FEAT_BITS-1:0];
			// identify data reads this register directly
			maxLba_ff <= lbaWord_ff;
		end
	end

	assign cmdDone = done_ff;
	assign cmdAbort = abort_ff;
	assign fail_word_index = report_ff.failWordIndex;
	assign fail_bit_mask_high = report_ff.failBitMask[15:8];
	assign fail_bit_mask_low = report_ff.failBitMask[7:0];
	assign vendor_result_byte = report_ff.vendorResult;
	assign drive_select_reg = drvReg_ff;
	assign udmaSupport = udma_ff;
	assign featureSupport = feat_ff;
	assign identMaxLba = maxLba_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_check;
		state_ff == CHECK;
	endsequence

	sequence s_failed_check;
		state_ff == CHECK ##0 anyFail;
	endsequence

	a_freeze_aborts: assert property (
		s_check ##0 devState.freezeLock |=> cmdDone && cmdAbort)
		else $error("freeze lock did not abort");

	a_fail_keeps_cfg: assert property (
		s_failed_check |=> $stable(udma_ff) && $stable(feat_ff) &&
			$stable(maxLba_ff))
		else $error("configuration changed on abort");

	a_lba_commit: assert property (
		s_check ##0 !anyFail |=> identMaxLba == $past(lbaWord_ff))
		else $error("maximum address not committed");

	a_prot_lba_hold: assert property (
		s_check ##0 devState.protectedHostArea &&
			(lbaWord_ff != maxLba_ff) |=> cmdAbort && $stable(identMaxLba))
		else $error("protected area did not pin address");

	a_udma_clear_bad: assert property (
		s_check ##0 !devState.freezeLock && !failInteg && udma_ff[0] &&
			!udmaWord_ff[0] && udmaWord_ff[1]
			|=> cmdAbort && fail_bit_mask_low[0])
		else $error("illegal dma bit 0 clear accepted");

	a_udma_mode_bad: assert property (
		s_check ##0 !devState.freezeLock && !failInteg && udma_ff[2] &&
			!udmaWord_ff[2] && devState.udmaSelected &&
			devState.udmaMode >= 3'h2
			|=> cmdAbort && fail_word_index == WORD_UDMA &&
			fail_bit_mask_low[2])
		else $error("dma bit 2 clear under selected mode accepted");

	a_smart_clear_bad: assert property (
		s_check ##0 !devState.freezeLock && !failInteg && !failUdma &&
			feat_ff[FEAT_SMART] && !featWord_ff[FEAT_SMART] &&
			devState.smartEnabled
			|=> cmdAbort && fail_word_index == WORD_FEATURE &&
			fail_bit_mask_low[FEAT_SMART])
		else $error("monitoring flag clear not refused");

	a_sec_clear_bad: assert property (
		s_check ##0 !devState.freezeLock && !failInteg && !failUdma &&
			devState.securityEnabled && feat_ff[FEAT_SECURITY] &&
			!featWord_ff[FEAT_SECURITY]
			|=> cmdAbort && fail_word_index == WORD_FEATURE &&
			fail_bit_mask_low[FEAT_SECURITY])
		else $error("security flag clear not reported");

	a_sig_checked: assert property (
		s_check ##0 integWord_ff[7:0] != SIGNATURE_VALUE |=> cmdAbort)
		else $error("bad signature accepted");

	a_clean_report: assert property (
		s_check ##0 !anyFail |=> !cmdAbort && fail_word_index == 8'h00 &&
			fail_bit_mask_high == 8'h00 && fail_bit_mask_low == 8'h00)
		else $error("report not zero after success");

	a_vendor_byte: assert property (
		cmdDone |-> vendor_result_byte == VENDOR_RESULT)
		else $error("vendor byte missing");

	a_done_after_all: assert property (
		state_ff == RECV && lastWord |=> s_check ##1 cmdDone)
		else $error("done not two cycles after last word");

endmodule // config_overlay_validator

`default_nettype wire

// file: testbench/host_model.sv
/*
 * Host side model: issues configuration-set commands with 256-word overlays.
 * Assumes the bench calls send() and drives nothing else of this interface.
 */
`timescale 1ns/1ps
`default_nettype none

module host_model
	import overlay_pkg::*;
(
	input wire logic clock, // Core clock
	output logic cmdStart, // Command start pulse
	output logic dataValid, // Word strobe
	output logic [15:0] dataWord // Overlay word
);
	// ------------------------------------------------
	// Overlay build and transfer
	// ------------------------------------------------
	initial begin
		cmdStart = 1'b0;
		dataValid = 1'b0;
		dataWord = 16'h0000;
	end

	// Corrupt: 1 checksum, 2 signature, 3 revision; gaps idles between words
	task automatic send(input logic [2:0] udma, input logic [8:0] feat,
		input logic [63:0] lba, input int corrupt, input bit gaps);
		logic [15:0] w [256];
		logic [7:0] s;
		logic [7:0] sig;
		s = 8'h00;
		// Reserved words carry a varied pattern that must not matter
		for (int i = 0; i < 255; i++) begin
			w[i] = {8'(i * 3), 8'(~i)};
		end
		w[0] = (corrupt == 3) ? 16'h0002 : REVISION_VALUE;
		w[2] = {13'h0000, udma};
		for (int k = 0; k < 4; k++) begin
			w[3 + k] = lba[16 * k +: 16];
		end
		w[7] = {7'h00, feat};
		sig = (corrupt == 2) ? 8'h5B : SIGNATURE_VALUE;
		// byte sum of the whole overlay is zero
		for (int i = 0; i < 255; i++) begin
			s = s + w[i][7:0] + w[i][15:8];
		end
		s = s + sig;
		w[255] = {(8'h00 - s) ^ ((corrupt == 1) ? 8'h01 : 8'h00), sig};
		@(negedge clock);
		cmdStart = 1'b1;
		@(negedge clock);
		cmdStart = 1'b0;
		for (int i = 0; i < 256; i++) begin
			dataValid = 1'b1;
			dataWord = w[i];
			@(negedge clock);
			if (gaps && i != 255) begin
				dataValid = 1'b0;
				dataWord = ~w[i];
				@(negedge clock);
			end
		end
		// Released bus shows the inverse, never a stale word
		dataValid = 1'b0;
		dataWord = ~w[255];
	endtask
endmodule // host_model

`default_nettype wire

// file: testbench/tb_top.sv
/*
 * Self-checking bench for the configuration overlay validator.
 * Assumes the validator and its package as declared in verilog/.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import overlay_pkg::*;

	// ------------------------------------------------
	// Signals and instances
	// ------------------------------------------------
	typedef struct {
		logic [2:0] u;
		logic [8:0] f;
		logic [63:0] l;
		dev_state_s d;
		int c;
		logic ab;
		logic [7:0] idx;
		logic [15:0] m;
	} row_s;

	logic clock, rst_n, cmdStart, dataValid, cmdDone, cmdAbort;
	logic [15:0] dataWord;
	logic drvSel;
	dev_state_s devState;
	logic [7:0] idxOut, mHi, mLo, vend, drvReg;
	logic [2:0] udmaOut, curU;
	logic [8:0] featOut, curF;
	logic [63:0] lbaOut, curL;
	int err_count, n_compared, cycles;
	row_s rows [16] = '{
		'{3'h7, 9'h1FF, 64'h1000, 8'h00, 0, 1'b0, 8'h00, 16'h0000},
		'{3'h3, 9'h1FF, 64'h1000, 8'h00, 0, 1'b0, 8'h00, 16'h0000},
		'{3'h7, 9'h1FF, 64'h1000, 8'h00, 0, 1'b0, 8'h00, 16'h0000},
		'{3'h3, 9'h1FF, 64'h1000, 8'h0A, 0, 1'b1, 8'h02, 16'h0004},
		'{3'h5, 9'h1FF, 64'h1000, 8'h00, 0, 1'b1, 8'h02, 16'h0002},
		'{3'h6, 9'h1FF, 64'h1000, 8'h00, 0, 1'b1, 8'h02, 16'h0001},
		'{3'h7, 9'h17F, 64'h1000, 8'h40, 0, 1'b1, 8'h07, 16'h0080},
		'{3'h7, 9'h1F7, 64'h1000, 8'h20, 0, 1'b1, 8'h07, 16'h0008},
		'{3'h7, 9'h1FE, 64'h1000, 8'h00, 0, 1'b1, 8'h07, 16'h0001},
		'{3'h7, 9'h089, 64'h1000, 8'h00, 0, 1'b0, 8'h00, 16'h0000},
		'{3'h7, 9'h088, 64'h1000, 8'h10, 0, 1'b1, 8'h07, 16'h0001},
		'{3'h7, 9'h089, 64'h2000, 8'h40, 0, 1'b1, 8'h03, 16'h0000},
		'{3'h7, 9'h089, 64'h1000, 8'h80, 0, 1'b1, 8'h00, 16'h0000},
		'{3'h7, 9'h089, 64'h1000, 8'h00, 1, 1'b1, 8'h00, 16'h0000},
		'{3'h7, 9'h089, 64'h1000, 8'h00, 2, 1'b1, 8'h00, 16'h0000},
		'{3'h7, 9'h089, 64'h1000, 8'h00, 3, 1'b1, 8'h00, 16'h0000}
	};

	host_model HOST (.clock(clock), .cmdStart(cmdStart),
		.dataValid(dataValid), .dataWord(dataWord));

	config_overlay_validator DUT (.clock(clock), .rst_n(rst_n),
		.cmdStart(cmdStart), .dataValid(dataValid), .dataWord(dataWord),
		.devState(devState), .drive_select_bit(drvSel), .cmdDone(cmdDone),
		.cmdAbort(cmdAbort), .fail_word_index(idxOut),
		.fail_bit_mask_high(mHi), .fail_bit_mask_low(mLo),
		.vendor_result_byte(vend), .drive_select_reg(drvReg),
		.udmaSupport(udmaOut), .featureSupport(featOut),
		.identMaxLba(lbaOut));

	// ------------------------------------------------
	// Clock, timeout and checking helpers
	// ------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// About twenty commands of some 260 cycles fit well below this ceiling
	always @(posedge clock) begin
		cycles++;
		if (cycles >= 20000) begin
			err_count++;
			wrap_up();
		end
	end

	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chkCfg();
		chk("udmaSupport", 64'(curU), 64'(udmaOut));
		chk("featureSupport", 64'(curF), 64'(featOut));
		chk("identMaxLba", curL, lbaOut);
	endtask

	// One command; the answer comes two edges after the last word
	task automatic doOne(input row_s r, input bit gaps);
		devState = r.d;
		HOST.send(r.u, r.f, r.l, r.c, gaps);
		chk("doneEarly", 64'h0, 64'(cmdDone));
		@(negedge clock);
		chk("cmdDone", 64'h1, 64'(cmdDone));
		if (!r.ab) begin
			curU = r.u;
			curF = r.f;
			curL = r.l;
		end
		chk("cmdAbort", 64'(r.ab), 64'(cmdAbort));
		chk("failWordIndex", 64'(r.idx), 64'(idxOut));
		chk("failBitMask", 64'(r.m), 64'({mHi, mLo}));
		chk("vendorResult", 64'(VENDOR_RESULT), 64'(vend));
		chkCfg();
		@(negedge clock);
		chk("donePulse", 64'h0, 64'(cmdDone));
	endtask

	task automatic wrap_up();
		if (err_count == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		rst_n = 1'b0;
		drvSel = 1'b0;
		devState = '0;
		err_count = 0;
		n_compared = 0;
		cycles = 0;
		curU = UDMA_RESET;
		curF = FEAT_RESET;
		curL = MAX_LBA_RESET;
		repeat (10) @(negedge clock);
		rst_n = 1'b1;
		chk("vendorReset", 64'h0, 64'(vend));
		chk("driveSelReset", 64'h0, 64'(drvReg));
		chkCfg();
		foreach (rows[i]) begin
			doOne(rows[i], 1'b0);
		end
		// Drive select status shows the host's choice one cycle later
		drvSel = 1'b1;
		@(negedge clock);
		chk("driveSelect", 64'h10, 64'(drvReg));
		drvSel = 1'b0;
		@(negedge clock);
		chk("driveSelect", 64'h0, 64'(drvReg));
		// Idle cycles between words must not disturb the transfer
		doOne('{3'h7, 9'h089, 64'h3000, 8'h00, 0, 1'b0, 8'h00,
			16'h0000}, 1'b1);
		// Reset in mid transfer: no answer, configuration back to reset
		fork
			HOST.send(3'h3, 9'h001, 64'h4000, 0, 1'b0);
			begin
				repeat (60) @(negedge clock);
				rst_n = 1'b0;
				repeat (2) @(negedge clock);
				rst_n = 1'b1;
			end
		join
		repeat (4) @(negedge clock);
		chk("doneAfterReset", 64'h0, 64'(cmdDone));
		chk("vendorAfterReset", 64'h0, 64'(vend));
		chk("abortAfterReset", 64'h0, 64'(cmdAbort));
		curU = UDMA_RESET;
		curF = FEAT_RESET;
		curL = MAX_LBA_RESET;
		chkCfg();
		doOne(rows[0], 1'b0);
		wrap_up();
	end
endmodule // tb_top

`default_nettype wire
